// ### design/adc_conv_end.sv
/*
 * Converter end: power-mode control, frame sequencing and result
 * shifting of a single-channel 8-bit sampling converter.
 * Assumes sclk and cs_n come from another domain and are sampled by
 * mclk at well above twice the serial clock rate.
 */
// Summary of operation
// RULE_01 - Frame-select fall in shutdown starts power-up
// RULE_02 - First result after wake-up flagged invalid
// RULE_03 - Wake frame ended before 10th fall: shutdown
// RULE_04 - Host holds select past 10th fall
// RULE_05 - Sixteen clocks powers fully; next result valid
// RULE_06 - Host waits quiet time after dummy frame
// RULE_07 - Power-on mode either; first frame is dummy
// RULE_08 - Continuous normal mode: twenty clocks per sample
// RULE_09 - Host may end frames between falls 10-15
// RULE_10 - Track resumes at 13th rise; host waits acquisition
// RULE_11 - Sample and hold at frame-select fall
// RULE_12 - Sixteenth fall ends conversion, floats result line
// RULE_13 - Three zeros, eight bits MSB first, four zeros
// RULE_14 - Select rise between falls 2-10 enters shutdown
// RULE_15 - Select rise before 2nd fall keeps mode
// RULE_16 - Select rise after 10th fall truncates, stays normal
// RULE_17 - Power state changes only at select rise
`timescale 1ns/10ps
module adc_conv_end #(
    parameter bit START_NORMAL = 1'b0    // Mode assumed after reset
) (
    input  wire logic       mclk,        // System clock
    input  wire logic       reset,       // Asynchronous reset
    input  wire logic       ce,          // Clock enable
    adc_link_if.dev         link,        // Serial link to the master
    input  wire logic [7:0] sample_in,   // Analog value stand-in
    output logic            sample_take, // Input sampled this cycle
    output logic            holding,     // Hold phase in progress
    output logic            analog_on,   // Analog circuitry powered
    output logic            powered,     // Fully powered, results valid
    output logic [7:0]      word_out,    // Completed conversion word
    output logic            word_done,   // Word finished pulse
    output logic            word_dummy   // Finished word is invalid
);

    localparam logic [adc_link_pkg::EDGE_W-1:0] ONE = 5'h01;

    // Three-stage samplers for the pins
    logic [2:0] sclk_s_r;
    logic [2:0] cs_s_r;
    logic       sclk_f_r;
    logic       sclk_f_nxt;
    logic       cs_f_r;
    logic       cs_f_nxt;

    always_comb begin
        sclk_f_nxt = (sclk_s_r[1] == sclk_s_r[2]) ? sclk_s_r[2] : sclk_f_r;
        cs_f_nxt   = (cs_s_r[1] == cs_s_r[2]) ? cs_s_r[2] : cs_f_r;
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            sclk_s_r <= 3'h7;
            cs_s_r   <= 3'h7;
            sclk_f_r <= 1'b1;
            cs_f_r   <= 1'b1;
        end else if (ce) begin
            sclk_s_r <= {sclk_s_r[1:0], link.sclk};
            cs_s_r   <= {cs_s_r[1:0], link.cs_n};
            sclk_f_r <= sclk_f_nxt;
            cs_f_r   <= cs_f_nxt;
        end
    end

    logic sclk_fall;
    logic sclk_rise;
    logic cs_fall;
    logic cs_rise;

    assign sclk_fall = sclk_f_r & ~sclk_f_nxt;
    assign sclk_rise = ~sclk_f_r & sclk_f_nxt;
    assign cs_fall   = cs_f_r & ~cs_f_nxt;
    assign cs_rise   = ~cs_f_r & cs_f_nxt;

    // Frame and power state
    adc_link_pkg::frame_e                  fr_r, fr_nxt;
    adc_link_pkg::power_e                  pw_r, pw_nxt;
    logic [adc_link_pkg::EDGE_W-1:0]       falls_r, falls_nxt;
    logic [adc_link_pkg::EDGE_W-1:0]       rises_r, rises_nxt;
    logic [adc_link_pkg::WORD_BITS-1:0]    sh_r, sh_nxt;
    logic [7:0]                            samp_r, samp_nxt;
    logic [7:0]                            word_r, word_nxt;
    logic                                  wake_r, wake_nxt;
    logic                                  rdy_r, rdy_nxt;
    logic                                  dum_r, dum_nxt;
    logic                                  wdum_r, wdum_nxt;
    logic                                  done_r, done_nxt;
    logic                                  take_r, take_nxt;
    logic                                  hold_r, hold_nxt;
    logic                                  out_r, out_nxt;
    logic                                  oe_r, oe_nxt;
    adc_link_pkg::power_e                  pw_end;

    always_comb begin
        fr_nxt    = fr_r;
        pw_nxt    = pw_r;
        falls_nxt = falls_r;
        rises_nxt = rises_r;
        sh_nxt    = sh_r;
        samp_nxt  = samp_r;
        word_nxt  = word_r;
        wake_nxt  = wake_r;
        rdy_nxt   = rdy_r;
        dum_nxt   = dum_r;
        wdum_nxt  = wdum_r;
        done_nxt  = 1'b0;
        take_nxt  = 1'b0;
        hold_nxt  = hold_r;
        out_nxt   = out_r;
        oe_nxt    = oe_r;
        pw_end    = pw_r;

        // Mode reached if the select rose now
        if (wake_r) begin
            pw_end = (falls_r >= adc_link_pkg::FALLS_NORMAL) ?
                     adc_link_pkg::PW_NORMAL :
                     adc_link_pkg::PW_SHUTDOWN;                       // RULE_03
        end else if (falls_r >= adc_link_pkg::FALLS_NOISE &&
                     falls_r < adc_link_pkg::FALLS_NORMAL) begin
            pw_end = adc_link_pkg::PW_SHUTDOWN;                       // RULE_14
        end

        if (cs_fall) begin
            // A new frame always starts, even over an idled-low frame
            fr_nxt    = adc_link_pkg::FR_ACTIVE;
            falls_nxt = '0;
            rises_nxt = '0;
            wake_nxt  = (pw_r == adc_link_pkg::PW_SHUTDOWN);          // RULE_01
            dum_nxt   = ~rdy_r;                                       // RULE_02 RULE_07
            hold_nxt  = 1'b1;                                         // RULE_11
            take_nxt  = 1'b1;                                         // RULE_11
            samp_nxt  = sample_in;                                    // RULE_11
            sh_nxt    = {{adc_link_pkg::LEAD_ZEROS{1'b0}}, sample_in,
                         {adc_link_pkg::TRAIL_ZEROS{1'b0}}};          // RULE_13
            out_nxt   = 1'b0;
            oe_nxt    = 1'b1;
        end else if (cs_rise) begin
            fr_nxt   = adc_link_pkg::FR_IDLE;
            oe_nxt   = 1'b0;                                          // RULE_14 RULE_16
            hold_nxt = 1'b0;
            wake_nxt = 1'b0;
            pw_nxt   = pw_end;                                        // RULE_15 RULE_17
            if (pw_end == adc_link_pkg::PW_SHUTDOWN) begin
                rdy_nxt = 1'b0;
            end
        end else if (fr_r != adc_link_pkg::FR_IDLE) begin
            if (sclk_fall && fr_r == adc_link_pkg::FR_ACTIVE) begin
                falls_nxt = falls_r + ONE;
                sh_nxt    = {sh_r[adc_link_pkg::WORD_BITS-2:0], 1'b0};  // RULE_13
                out_nxt   = sh_r[adc_link_pkg::WORD_BITS-2];           // RULE_13
                if (falls_nxt == adc_link_pkg::FALLS_END) begin
                    fr_nxt   = adc_link_pkg::FR_DONE;
                    oe_nxt   = 1'b0;                                  // RULE_12
                    word_nxt = samp_r;                                // RULE_12
                    wdum_nxt = dum_r;                                 // RULE_02
                    done_nxt = 1'b1;
                    rdy_nxt  = 1'b1;                                  // RULE_05
                end
            end
            if (sclk_rise && rises_r != adc_link_pkg::EDGE_MAX) begin
                rises_nxt = rises_r + ONE;
                if (rises_nxt == adc_link_pkg::RISE_TRACK) begin
                    hold_nxt = 1'b0;                                  // RULE_10
                end
            end
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            fr_r    <= adc_link_pkg::FR_IDLE;
            pw_r    <= START_NORMAL ? adc_link_pkg::PW_NORMAL :
                                      adc_link_pkg::PW_SHUTDOWN;       // RULE_07
            falls_r <= '0;
            rises_r <= '0;
            sh_r    <= '0;
            samp_r  <= 8'h00;
            word_r  <= 8'h00;
            wake_r  <= 1'b0;
            rdy_r   <= 1'b0;
            dum_r   <= 1'b0;
            wdum_r  <= 1'b0;
            done_r  <= 1'b0;
            take_r  <= 1'b0;
            hold_r  <= 1'b0;
            out_r   <= 1'b0;
            oe_r    <= 1'b0;
        end else if (ce) begin
            fr_r    <= fr_nxt;
            pw_r    <= pw_nxt;
            falls_r <= falls_nxt;
            rises_r <= rises_nxt;
            sh_r    <= sh_nxt;
            samp_r  <= samp_nxt;
            word_r  <= word_nxt;
            wake_r  <= wake_nxt;
            rdy_r   <= rdy_nxt;
            dum_r   <= dum_nxt;
            wdum_r  <= wdum_nxt;
            done_r  <= done_nxt;
            take_r  <= take_nxt;
            hold_r  <= hold_nxt;
            out_r   <= out_nxt;
            oe_r    <= oe_nxt;
        end
    end

    // Any frame in progress keeps the analog side awake
    assign analog_on = (pw_r == adc_link_pkg::PW_NORMAL) ||
                       (fr_r != adc_link_pkg::FR_IDLE);
    assign powered   = rdy_r;
    assign holding   = hold_r;
    assign sample_take = take_r;
    assign word_out  = word_r;
    assign word_done = done_r;
    assign word_dummy = wdum_r;

    assign link.serial_result_out = out_r;
    assign link.result_oe         = oe_r;

endmodule : adc_conv_end

// ### design/adc_link_pkg.sv
/*
 * Shared constants and types for the sampling converter serial link:
 * frame edge counts, word layout, timing figures and state enums.
 * Assumes both ends run on the same 25 MHz system clock rate.
 */
package adc_link_pkg;

    // Counter width for serial clock edges within one frame
    localparam int EDGE_W = 5;

    // Serial clock edge thresholds, counted from the frame-select fall
    localparam logic [EDGE_W-1:0] FALLS_NOISE  = 5'h02;
    localparam logic [EDGE_W-1:0] FALLS_NORMAL = 5'h0A;
    localparam logic [EDGE_W-1:0] FALLS_END    = 5'h10;
    localparam logic [EDGE_W-1:0] RISE_TRACK   = 5'h0D;
    localparam logic [EDGE_W-1:0] FRAME_CYC    = 5'h14;
    localparam logic [EDGE_W-1:0] EDGE_MAX     = 5'h1F;

    // Word layout on the result line
    localparam int LEAD_ZEROS  = 3;
    localparam int DATA_BITS   = 8;
    localparam int TRAIL_ZEROS = 4;
    localparam int WORD_BITS   = LEAD_ZEROS + DATA_BITS + TRAIL_ZEROS;

    // Falls at which the host captures the data bits, MSB first
    localparam logic [EDGE_W-1:0] CAPT_FIRST = 5'h04;
    localparam logic [EDGE_W-1:0] CAPT_LAST  = 5'h0B;

    // Timing figures in ns and their cycle counts at the system clock
    localparam int MCLK_NS  = 40;
    localparam int ACQ_NS   = 350;
    localparam int QUIET_NS = 50;
    localparam int TIMER_W  = 8;
    localparam logic [TIMER_W-1:0] TIMER_MAX = 8'hFF;
    localparam logic [TIMER_W-1:0] ACQ_CYC =
        TIMER_W'((ACQ_NS + MCLK_NS - 1) / MCLK_NS);
    localparam logic [TIMER_W-1:0] QUIET_CYC =
        TIMER_W'((QUIET_NS + MCLK_NS - 1) / MCLK_NS);

    // Default half period of the serial clock, in system clocks
    localparam int SCLK_HALF_DEF = 4;

    typedef enum {PW_SHUTDOWN, PW_NORMAL} power_e;
    typedef enum {FR_IDLE, FR_ACTIVE, FR_DONE} frame_e;
    typedef enum {H_IDLE, H_RUN} host_e;

endpackage : adc_link_pkg

// ### design/adc_link_if.sv
/*
 * Three-wire link between the converter end and the serial master end.
 * Resolves the result line from the converter's enable; a released
 * line reads high, as a pull-up would hold it.
 */
`timescale 1ns/10ps
interface adc_link_if;
    logic sclk;                 // Serial clock, made by the master
    logic cs_n;                 // Frame select, active low
    logic serial_result_out;    // Converter output value
    logic result_oe;            // Converter drives the line while high
    wire  serial_result_line;   // Resolved line level, high when released

    assign serial_result_line = result_oe ? serial_result_out : 1'b1;

    modport dev (
        input  sclk,
        input  cs_n,
        output serial_result_out,
        output result_oe
    );

    modport host (
        output sclk,
        output cs_n,
        input  serial_result_line
    );
endinterface : adc_link_if

// ### design/adc_master_end.sv
/*
 * Serial master end: makes the serial clock by division, frames each
 * conversion, keeps quiet gaps and, after frames reaching the 13th rise, acquisition gaps, captures the word and
 * models the converter's power mode to flag dummy results.
 * Assumes a converter end on the other side of adc_link_if.
 */
`timescale 1ns/10ps
module adc_master_end #(
    parameter int SCLK_HALF = adc_link_pkg::SCLK_HALF_DEF  // Half period
) (
    input  wire logic       mclk,        // System clock
    input  wire logic       reset,       // Asynchronous reset
    input  wire logic       ce,          // Clock enable
    adc_link_if.host        link,        // Serial link to the converter
    input  wire logic       start,       // Request a frame
    input  wire logic [4:0] stop_falls,  // Falls before select rises
    output logic            ready,       // Start would be taken now
    output logic            busy,        // Frame in progress
    output logic [7:0]      data_out,    // Captured word
    output logic            data_valid,  // Word captured pulse
    output logic            data_dummy,  // Captured word is a dummy
    output logic            mode_known,  // Converter mode is known
    output logic            mode_normal  // Converter left in normal mode
);

    localparam logic [adc_link_pkg::EDGE_W-1:0] ONE = 5'h01;
    localparam logic [7:0] DIV_LAST = 8'(SCLK_HALF - 1);

    // Result line sampler
    logic [2:0] line_s_r;
    logic       line_f_r;
    logic       line_f_nxt;

    always_comb begin
        line_f_nxt = (line_s_r[1] == line_s_r[2]) ? line_s_r[2] : line_f_r;
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            line_s_r <= 3'h0;
            line_f_r <= 1'b0;
        end else if (ce) begin
            line_s_r <= {line_s_r[1:0], link.serial_result_line};
            line_f_r <= line_f_nxt;
        end
    end

    adc_link_pkg::host_e                 st_r, st_nxt;
    logic [7:0]                          div_r, div_nxt;
    logic [adc_link_pkg::EDGE_W-1:0]     falls_r, falls_nxt;
    logic [adc_link_pkg::EDGE_W-1:0]     rises_r, rises_nxt;
    logic [adc_link_pkg::EDGE_W-1:0]     stop_r, stop_nxt;
    logic [adc_link_pkg::TIMER_W-1:0]    acq_r, acq_nxt;
    logic [adc_link_pkg::TIMER_W-1:0]    qt_r, qt_nxt;
    logic [7:0]                          cap_r, cap_nxt;
    logic [7:0]                          data_r, data_nxt;
    logic                                sclk_r, sclk_nxt;
    logic                                cs_r, cs_nxt;
    logic                                known_r, known_nxt;
    logic                                norm_r, norm_nxt;
    logic                                prim_r, prim_nxt;
    logic                                fdum_r, fdum_nxt;
    logic                                dum_r, dum_nxt;
    logic                                val_r, val_nxt;
    logic                                gap_ok;

    assign gap_ok = (acq_r >= adc_link_pkg::ACQ_CYC) &&                // RULE_10
                    (qt_r >= adc_link_pkg::QUIET_CYC);                 // RULE_06

    always_comb begin
        st_nxt    = st_r;
        div_nxt   = div_r;
        falls_nxt = falls_r;
        rises_nxt = rises_r;
        stop_nxt  = stop_r;
        acq_nxt   = (acq_r == adc_link_pkg::TIMER_MAX) ? acq_r : acq_r + 8'h01;
        qt_nxt    = (qt_r == adc_link_pkg::TIMER_MAX) ? qt_r : qt_r + 8'h01;
        cap_nxt   = cap_r;
        data_nxt  = data_r;
        sclk_nxt  = sclk_r;
        cs_nxt    = cs_r;
        known_nxt = known_r;
        norm_nxt  = norm_r;
        prim_nxt  = prim_r;
        fdum_nxt  = fdum_r;
        dum_nxt   = dum_r;
        val_nxt   = 1'b0;
        case (st_r)
            adc_link_pkg::H_IDLE: begin
                if (start && gap_ok) begin
                    st_nxt    = adc_link_pkg::H_RUN;
                    cs_nxt    = 1'b0;
                    div_nxt   = 8'h00;
                    falls_nxt = '0;
                    rises_nxt = '0;
                    fdum_nxt  = ~prim_r;                              // RULE_02 RULE_07
                    stop_nxt  = (stop_falls > adc_link_pkg::FRAME_CYC) ?
                                adc_link_pkg::FRAME_CYC : stop_falls; // RULE_08
                end
            end
            adc_link_pkg::H_RUN: begin
                if (div_r != DIV_LAST) begin
                    div_nxt = div_r + 8'h01;
                end else begin
                    div_nxt = 8'h00;
                    if (sclk_r && rises_r == stop_r) begin
                        // Select rises only while the clock is high
                        st_nxt = adc_link_pkg::H_IDLE;
                        cs_nxt = 1'b1;
                        qt_nxt = '0;                                  // RULE_06
                        if (falls_r >= adc_link_pkg::FALLS_NORMAL) begin
                            known_nxt = 1'b1;                         // RULE_04 RULE_09
                            norm_nxt  = 1'b1;
                        end else if (falls_r >= adc_link_pkg::FALLS_NOISE ||
                                     (known_r && !norm_r)) begin
                            known_nxt = 1'b1;                         // RULE_14 RULE_03
                            norm_nxt  = 1'b0;
                        end
                        if (falls_r >= adc_link_pkg::FALLS_END) begin
                            prim_nxt = 1'b1;                          // RULE_05
                        end
                        if (known_nxt && !norm_nxt) begin
                            prim_nxt = 1'b0;
                        end
                        if (falls_r >= adc_link_pkg::CAPT_LAST) begin
                            data_nxt = cap_r;
                            dum_nxt  = fdum_r;                        // RULE_02
                            val_nxt  = 1'b1;
                        end
                    end else if (sclk_r) begin
                        sclk_nxt  = 1'b0;
                        falls_nxt = falls_r + ONE;
                        if (falls_nxt >= adc_link_pkg::CAPT_FIRST &&
                            falls_nxt <= adc_link_pkg::CAPT_LAST) begin
                            // Filter's next value: round trip is a full period
                            cap_nxt = {cap_r[6:0], line_f_nxt};       // RULE_13
                        end
                    end else begin
                        sclk_nxt  = 1'b1;
                        rises_nxt = rises_r + ONE;
                        if (rises_nxt == adc_link_pkg::RISE_TRACK) begin
                            acq_nxt = '0;                             // RULE_10
                        end
                    end
                end
            end
            default: begin
                st_nxt = adc_link_pkg::H_IDLE;
                cs_nxt = 1'b1;
            end
        endcase
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            st_r    <= adc_link_pkg::H_IDLE;
            div_r   <= 8'h00;
            falls_r <= '0;
            rises_r <= '0;
            stop_r  <= '0;
            acq_r   <= adc_link_pkg::TIMER_MAX;
            qt_r    <= adc_link_pkg::TIMER_MAX;
            cap_r   <= 8'h00;
            data_r  <= 8'h00;
            sclk_r  <= 1'b1;
            cs_r    <= 1'b1;
            known_r <= 1'b0;
            norm_r  <= 1'b0;
            prim_r  <= 1'b0;
            fdum_r  <= 1'b0;
            dum_r   <= 1'b0;
            val_r   <= 1'b0;
        end else if (ce) begin
            st_r    <= st_nxt;
            div_r   <= div_nxt;
            falls_r <= falls_nxt;
            rises_r <= rises_nxt;
            stop_r  <= stop_nxt;
            acq_r   <= acq_nxt;
            qt_r    <= qt_nxt;
            cap_r   <= cap_nxt;
            data_r  <= data_nxt;
            sclk_r  <= sclk_nxt;
            cs_r    <= cs_nxt;
            known_r <= known_nxt;
            norm_r  <= norm_nxt;
            prim_r  <= prim_nxt;
            fdum_r  <= fdum_nxt;
            dum_r   <= dum_nxt;
            val_r   <= val_nxt;
        end
    end

    assign ready       = (st_r == adc_link_pkg::H_IDLE) && gap_ok;
    assign busy        = (st_r == adc_link_pkg::H_RUN);
    assign data_out    = data_r;
    assign data_valid  = val_r;
    assign data_dummy  = dum_r;
    assign mode_known  = known_r;
    assign mode_normal = norm_r;
    assign link.sclk   = sclk_r;
    assign link.cs_n   = cs_r;

endmodule : adc_master_end

// ### dv/adc_link_props.sv
/* Checker on the link wires between converter end and master end.
   Assumes both ends share mclk and the asynchronous reset. */
`timescale 1ns/10ps
module adc_link_props (
    input wire logic mclk,              // System clock
    input wire logic reset,             // Async reset, active high
    input wire logic sclk,              // Serial clock
    input wire logic cs_n,              // Frame select
    input wire logic serial_result_out, // Converter bit value
    input wire logic result_oe          // Converter drive enable
);
    logic       sclk_q_r;
    logic [4:0] falls_r, falls_nxt;
    logic [4:0] rises_r, rises_nxt;
    logic [7:0] gap_r, gap_nxt;

    // Gap restarts at the 13th rise, where tracking resumes
    always_comb begin
        falls_nxt = cs_n ? 5'h00 : falls_r;
        rises_nxt = cs_n ? 5'h00 : rises_r;
        gap_nxt   = (gap_r == 8'hFF) ? gap_r : gap_r + 8'h01;
        if (!cs_n && sclk_q_r && !sclk) falls_nxt = falls_r + 5'h01;
        if (!cs_n && !sclk_q_r && sclk) rises_nxt = rises_r + 5'h01;
        if (!cs_n && !sclk_q_r && sclk && rises_r == 5'h0C) gap_nxt = 8'h00;
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            sclk_q_r <= 1'b1;
            falls_r  <= 5'h00;
            rises_r  <= 5'h00;
            gap_r    <= 8'hFF;
        end else begin
            sclk_q_r <= sclk;
            falls_r  <= falls_nxt;
            rises_r  <= rises_nxt;
            gap_r    <= gap_nxt;
        end
    end

    default clocking @(posedge mclk); endclocking
    default disable iff (reset);

    property p_oe_on_select; $fell(cs_n) |-> ##[1:8] result_oe; endproperty
    a_oe_on_select: assert property (p_oe_on_select) else $error("line not driven");
    property p_float_release; $rose(cs_n) |-> ##[1:8] !result_oe; endproperty
    a_float_release: assert property (p_float_release) else $error("line held");
    property p_float_idle; cs_n [*8] |-> !result_oe; endproperty
    a_float_idle: assert property (p_float_idle) else $error("line driven idle");
    property p_end_float; falls_r == 5'h10 |-> ##[0:6] !result_oe; endproperty
    a_end_float: assert property (p_end_float) else $error("line held at end");
    // Falls 1, 2 and 12 to 15 only ever show padding zeros
    property p_zero_pad;
        !cs_n && result_oe && (falls_r inside {5'h01, 5'h02, [5'h0C:5'h0F]})
            |-> !serial_result_out;
    endproperty
    a_zero_pad: assert property (p_zero_pad) else $error("pad bit not zero");
    property p_acq_gap; $fell(cs_n) |-> gap_r >= adc_link_pkg::ACQ_CYC - 8'h01; endproperty
    a_acq_gap: assert property (p_acq_gap) else $error("acquire gap short");
    property p_quiet; $rose(cs_n) |-> cs_n [*2]; endproperty
    a_quiet: assert property (p_quiet) else $error("quiet gap short");
    property p_frame_len; !cs_n |-> falls_r <= adc_link_pkg::FRAME_CYC; endproperty
    a_frame_len: assert property (p_frame_len) else $error("frame too long");
endmodule : adc_link_props

// ### dv/testbench.sv
/* Self-checking bench: converter end and master end joined by the link,
   checker beside the link. Assumes the design package and interface. */
`timescale 1ns/10ps
module testbench;
    logic        mclk, reset, start, pw, mode, known, word_dummy;
    logic        ready, busy, data_valid, data_dummy, mode_known, mode_normal, powered;
    logic [4:0]  stop_falls;
    logic [7:0]  sample_in, data_out, word_out;
    logic [8:0]  exp_w;
    logic [8:0]  expq[$];
    logic [31:0] seed;
    int          failures, num_checks;
    logic [4:0]  plan [18] = '{5'h14, 5'h14, 5'h10, 5'h0C, 5'h0F, 5'h01, 5'h05, 5'h08,
        5'h0A, 5'h0B, 5'h10, 5'h0E, 5'h0A, 5'h09, 5'h10, 5'h00, 5'h02, 5'h0B};

    adc_link_if u_adc_link_if ();
    adc_conv_end u_adc_conv_end (.mclk(mclk), .reset(reset), .ce(1'b1),
        .link(u_adc_link_if.dev), .sample_in(sample_in), .sample_take(), .holding(),
        .analog_on(), .powered(powered), .word_out(word_out), .word_done(),
        .word_dummy(word_dummy));
    adc_master_end u_adc_master_end (.mclk(mclk), .reset(reset), .ce(1'b1),
        .link(u_adc_link_if.host), .start(start), .stop_falls(stop_falls), .ready(ready),
        .busy(busy), .data_out(data_out), .data_valid(data_valid),
        .data_dummy(data_dummy), .mode_known(mode_known), .mode_normal(mode_normal));
    adc_link_props u_adc_link_props (.mclk(mclk), .reset(reset), .sclk(u_adc_link_if.sclk),
        .cs_n(u_adc_link_if.cs_n), .serial_result_out(u_adc_link_if.serial_result_out),
        .result_oe(u_adc_link_if.result_oe));

    initial mclk = 1'b0;
    always #20 mclk = ~mclk;

    function automatic logic [31:0] xorshift(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xorshift

    task automatic check(input logic [8:0] got, input logic [8:0] exp);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic results();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : results

    task automatic do_reset();
        reset = 1'b1;
        repeat (3) @(negedge mclk);
        reset = 1'b0;
        expq.delete();
        pw = 1'b0;
        mode = 1'b0;
        known = 1'b0;
    endtask : do_reset

    task automatic frame(input logic [4:0] n);
        int k;
        seed = xorshift(seed);
        sample_in = seed[7:0];
        stop_falls = n;
        for (k = 0; k < 300 && ready !== 1'b1; k++) @(negedge mclk);
        if (k >= 300) failures++;
        if (k >= 300) results();
        if (n >= 5'h0B) expq.push_back({~pw, seed[7:0]});
        start = 1'b1;
        @(negedge mclk);
        start = 1'b0;
        for (k = 0; k < 2000 && busy !== 1'b0; k++) @(negedge mclk);
        if (k >= 2000) failures++;
        if (k >= 2000) results();
        // Converter takes the select rise a few clocks after the master
        repeat (6) @(negedge mclk);
        if (n >= 5'h10) check({word_dummy, word_out}, {~pw, sample_in});
        if (n >= 5'h10) pw = 1'b1;
        if (!mode) mode = (n >= 5'h0A);
        else if (n >= 5'h02 && n < 5'h0A) mode = 1'b0;
        if (!mode) pw = 1'b0;
        if (n >= 5'h02) known = 1'b1;
        check({8'h00, mode_known}, {8'h00, known});
        if (known) check({8'h00, mode_normal}, {8'h00, mode});
        check({8'h00, powered}, {8'h00, pw});
        $display("frame of %0d falls done", n);
    endtask : frame

    always @(posedge mclk) begin
        if (!reset && data_valid === 1'b1) begin
            if (expq.size() == 0) begin
                failures++;
                $display("Error at %0t: got %h expected %h", $time, data_out, 8'h00);
            end else begin
                exp_w = expq.pop_front();
                if (exp_w[8]) check({data_dummy, 8'h00}, 9'h100);
                else check({data_dummy, data_out}, exp_w);
            end
        end
    end

    initial begin
        reset = 1'b1;
        start = 1'b0;
        stop_falls = 5'h00;
        sample_in = 8'h00;
        seed = 32'h000085CD;
        failures = 0;
        num_checks = 0;
        do_reset();
        foreach (plan[i]) frame(plan[i]);
        do_reset();
        frame(5'h14);
        repeat (12) begin
            seed = xorshift(seed);
            frame(5'(seed % 21));
        end
        repeat (20) @(negedge mclk);
        check(9'(expq.size()), 9'h000);
        results();
    end
endmodule : testbench
